// ===== src/crb_config_status_bank.sv
// How it works
// - input register reads live synchronised pin levels
// - output latch drives pin in output mode
// - direction bit: 0 input, 1 output, resets 0
// - E/F/G function bit selects address-out mode
// - A/B/D/E/G drive bit selects open drain
// - C/F drive bit selects fast slew
// - main protect register reads per-sector protection
// - boot protect bits 3..0 report sector protection
// - boot protect bit 7 reports security lock
// - page register drives decode page, resets zero
// - power control 0 cleared only at power-up
// - power control 0 bit 1 enables auto power-down
// - power control 0 bit 3 turns fast mode off
// - power control 0 bit 4 disconnects logic clock
// - power gating bit 0 blocks address bits
// - power gating bits 2..4 block control inputs
// - power gating bits 5,6 block latch strobe, high-byte enable
// - space mapping loads config, effective in split mode
// - space bits 0..2 gate fetch strobe cycles
// - space bits 3,4 gate data read cycles
// - space bit 7 enables port F peripheral mode
// - size register low nibble reports main flash
// - size register high nibble reports SRAM
`timescale 1ns/10ps
module crb_config_status_bank #(
    parameter logic [3:0] MAIN_SIZE_CODE = 4'h5,
    parameter logic [3:0] SRAM_SIZE_CODE = 4'h3
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_por,
    input wire crb_pkg::crb_host_req_type i_host,
    input wire logic [crb_pkg::NUM_PORTS-1:0][7:0] i_pin_level,
    input wire logic [7:0] i_addr_latch,
    input wire logic [7:0] i_main_protect,
    input wire logic [3:0] i_boot_protect,
    input wire logic i_security_set,
    input wire logic [3:0] i_cfg_space_map,
    input wire logic i_split_bus_mode,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output crb_pkg::crb_pin_drive_type [crb_pkg::NUM_PORTS-1:0] o_pin_drive,
    output logic [crb_pkg::NUM_PORTS-1:0][7:0] o_slew_fast,
    output logic [7:0] o_page_bits,
    output logic o_auto_power_down,
    output logic o_logic_fast_mode_off,
    output logic o_logic_clock_input_block,
    output logic o_addr_block,
    output logic [2:0] o_control_inputs_block,
    output logic o_ale_block,
    output logic o_high_byte_write_enable_block,
    output logic [4:0] o_space_access_en,
    output logic o_port_f_periph_en
);

    localparam int NP = crb_pkg::NUM_PORTS;

    // size codes above the largest defined encoding cannot be reported
    if (MAIN_SIZE_CODE > crb_pkg::MAIN_SIZE_MAX || SRAM_SIZE_CODE > crb_pkg::SRAM_SIZE_MAX) begin
        $error("crb_config_status_bank: size code out of range");
    end

    logic [NP-1:0][7:0] pin_meta_q;
    logic [NP-1:0][7:0] pin_sync_q;
    logic [NP-1:0][7:0] out_q;
    logic [NP-1:0][7:0] dir_q;
    logic [NP-1:0][7:0] func_q;
    logic [NP-1:0][7:0] drive_q;
    logic [7:0] page_q;
    logic [7:0] pwr0_q;
    logic [7:0] pwr2_q;
    logic [7:0] space_q;
    logic cfg_load_q;
    logic [7:0] rdata_d;

    // a host write strobe aimed at one offset
    function automatic logic wr_hit(input crb_pkg::crb_host_req_type req,
                                    input logic [7:0] ofs);
        wr_hit = req.sel & req.wr & (req.addr == ofs);
    endfunction : wr_hit

    // pins are asynchronous to the core clock: two flops before any use
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= i_pin_level;
            pin_sync_q <= pin_meta_q;
        end
    end

    // per-port configuration latches; unmapped selects stay zero
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            out_q <= {NP{crb_pkg::PORT_REG_RST}};
            dir_q <= {NP{crb_pkg::PORT_REG_RST}};
            func_q <= {NP{crb_pkg::PORT_REG_RST}};
            drive_q <= {NP{crb_pkg::PORT_REG_RST}};
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (wr_hit(i_host, crb_pkg::OFS_DATA_OUT[p])) begin
                    out_q[p] <= i_host.wdata;
                end
                if (wr_hit(i_host, crb_pkg::OFS_DIR[p])) begin
                    dir_q[p] <= i_host.wdata;
                end
                if (crb_pkg::HAS_FUNC[p] && wr_hit(i_host, crb_pkg::OFS_FUNC[p])) begin
                    func_q[p] <= i_host.wdata;
                end
                if (wr_hit(i_host, crb_pkg::OFS_DRIVE[p])) begin
                    drive_q[p] <= i_host.wdata;
                end
            end
        end
    end

    // page register feeds the decode logic directly
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            page_q <= crb_pkg::PAGE_RST;
        end else if (wr_hit(i_host, crb_pkg::OFS_PAGE)) begin
            page_q <= i_host.wdata;
        end
    end

    // power control 0 survives device reset; only power-up clears it
    always_ff @(posedge i_core_clk or posedge i_por) begin
        if (i_por) begin
            pwr0_q <= crb_pkg::PWR_RST;
        end else if (wr_hit(i_host, crb_pkg::OFS_PWR0)) begin
            pwr0_q <= i_host.wdata & crb_pkg::PWR0_MASK;
        end
    end

    // signal gating into the logic array
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pwr2_q <= crb_pkg::PWR_RST;
        end else if (wr_hit(i_host, crb_pkg::OFS_PWR2)) begin
            pwr2_q <= i_host.wdata & crb_pkg::PWR2_MASK;
        end
    end

    // the config field cannot enter through the async reset, so it is
    // loaded on the first edge after release; that load beats a host write
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            space_q <= crb_pkg::SPACE_RST;
            cfg_load_q <= 1'b1;
        end else begin
            cfg_load_q <= 1'b0;
            if (cfg_load_q) begin
                space_q <= {3'h0, i_cfg_space_map, 1'b0};
            end else if (wr_hit(i_host, crb_pkg::OFS_SPACE)) begin
                space_q <= i_host.wdata & crb_pkg::SPACE_MASK;
            end
        end
    end

    // read mux; read-only sources sampled at the strobe edge
    always_comb begin
        rdata_d = 8'h00;
        for (int p = 0; p < NP; p++) begin
            if (i_host.addr == crb_pkg::OFS_DATA_IN[p]) rdata_d = pin_sync_q[p];
            if (i_host.addr == crb_pkg::OFS_DATA_OUT[p]) rdata_d = out_q[p];
            if (i_host.addr == crb_pkg::OFS_DIR[p]) rdata_d = dir_q[p];
            if (i_host.addr == crb_pkg::OFS_DRIVE[p]) rdata_d = drive_q[p];
            if (crb_pkg::HAS_FUNC[p] && i_host.addr == crb_pkg::OFS_FUNC[p]) begin
                rdata_d = func_q[p];
            end
        end
        case (i_host.addr)
            crb_pkg::OFS_MAIN_PROT: rdata_d = i_main_protect;
            crb_pkg::OFS_BOOT_PROT: rdata_d = {i_security_set, 3'h0, i_boot_protect};
            crb_pkg::OFS_PWR0: rdata_d = pwr0_q;
            crb_pkg::OFS_PWR2: rdata_d = pwr2_q;
            crb_pkg::OFS_PAGE: rdata_d = page_q;
            crb_pkg::OFS_SPACE: rdata_d = space_q;
            crb_pkg::OFS_MEM_SIZE: rdata_d = {SRAM_SIZE_CODE, MAIN_SIZE_CODE};
            default: ;
        endcase
    end

    // one read answer per strobe, one cycle later
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_host.sel & i_host.rd;
            o_rdata <= (i_host.sel & i_host.rd) ? rdata_d : 8'h00;
        end
    end

    // pad drive: address-out mode forces drive; open drain only pulls low
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin_drive <= '0;
            o_slew_fast <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                for (int n = 0; n < 8; n++) begin
                    logic addr_mode;
                    logic lvl;
                    logic drv;
                    addr_mode = crb_pkg::HAS_FUNC[p] & func_q[p][n];
                    lvl = addr_mode ? i_addr_latch[n] : out_q[p][n];
                    drv = addr_mode | dir_q[p][n];
                    if (crb_pkg::HAS_OPEN_DRAIN[p] && drive_q[p][n]) begin
                        o_pin_drive[p].oe[n] <= drv & ~lvl;
                    end else begin
                        o_pin_drive[p].oe[n] <= drv;
                    end
                    o_pin_drive[p].level[n] <= lvl;
                    o_slew_fast[p][n] <= crb_pkg::HAS_SLEW[p] & drive_q[p][n];
                end
            end
        end
    end

    // outside split bus mode the mapping bits have no effect: all allowed
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_space_access_en <= 5'h1F;
        end else begin
            o_space_access_en <= i_split_bus_mode ? space_q[4:0] : 5'h1F;
        end
    end

    // control levels come straight from their register flops
    assign o_page_bits = page_q;
    assign o_auto_power_down = pwr0_q[crb_pkg::PWR0_APD_BIT];
    assign o_logic_fast_mode_off = pwr0_q[crb_pkg::PWR0_FAST_OFF_BIT];
    assign o_logic_clock_input_block = pwr0_q[crb_pkg::PWR0_CLK_OFF_BIT];
    assign o_addr_block = pwr2_q[crb_pkg::PWR2_ADDR_BIT];
    assign o_control_inputs_block = pwr2_q[crb_pkg::PWR2_CTL0_BIT +: 3];
    assign o_ale_block = pwr2_q[crb_pkg::PWR2_ALE_BIT];
    assign o_high_byte_write_enable_block = pwr2_q[crb_pkg::PWR2_WRH_BIT];
    assign o_port_f_periph_en = space_q[crb_pkg::SPACE_PERIPH_BIT];

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    property p_page_write;
        wr_hit(i_host, crb_pkg::OFS_PAGE) |=> o_page_bits == $past(i_host.wdata);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost");

    property p_pin_read;
        i_host.sel && i_host.rd && i_host.addr == crb_pkg::OFS_DATA_IN[0]
            |=> o_rvalid && o_rdata == $past(i_pin_level[0], 3);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

    property p_main_prot;
        i_host.sel && i_host.rd && i_host.addr == crb_pkg::OFS_MAIN_PROT
            |=> o_rdata == $past(i_main_protect);
    endproperty
    a_main_prot: assert property (p_main_prot) else $error("main protect read wrong");

    property p_boot_prot;
        i_host.sel && i_host.rd && i_host.addr == crb_pkg::OFS_BOOT_PROT
            |=> o_rdata == {$past(i_security_set), 3'h0, $past(i_boot_protect)};
    endproperty
    a_boot_prot: assert property (p_boot_prot) else $error("boot protect read wrong");

    property p_mem_size;
        i_host.sel && i_host.rd && i_host.addr == crb_pkg::OFS_MEM_SIZE
            |=> o_rdata == {SRAM_SIZE_CODE, MAIN_SIZE_CODE};
    endproperty
    a_mem_size: assert property (p_mem_size) else $error("size read wrong");

    property p_pwr0_mask;
        wr_hit(i_host, crb_pkg::OFS_PWR0)
            |=> pwr0_q == ($past(i_host.wdata) & crb_pkg::PWR0_MASK);
    endproperty
    a_pwr0_mask: assert property (p_pwr0_mask) else $error("power control 0 write wrong");

    property p_pwr0_keep;
        @(posedge i_core_clk) disable iff (i_por)
            $rose(i_rst) |-> pwr0_q == $past(pwr0_q);
    endproperty
    a_pwr0_keep: assert property (p_pwr0_keep) else $error("reset cleared power control 0");

    property p_split;
        i_split_bus_mode ##1 i_split_bus_mode |=> o_space_access_en == $past(space_q[4:0]);
    endproperty
    a_split: assert property (p_split) else $error("space gating not applied");

    property p_no_split;
        !i_split_bus_mode |=> o_space_access_en == 5'h1F;
    endproperty
    a_no_split: assert property (p_no_split) else $error("space gating outside split mode");

    property p_push_pull;
        dir_q[0][0] && !drive_q[0][0] ##1 dir_q[0][0] && !drive_q[0][0]
            |=> o_pin_drive[0].oe[0] && o_pin_drive[0].level[0] == $past(out_q[0][0]);
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("port A pin 0 not driven");

    property p_dir_reset;
        @(posedge i_core_clk) $fell(i_rst) |-> dir_q == '0 && page_q == 8'h00;
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("reset values wrong");

    property p_read_answer;
        i_host.sel && i_host.rd |=> o_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    property p_stray_answer;
        !(i_host.sel && i_host.rd) |=> !o_rvalid && o_rdata == 8'h00;
    endproperty
    a_stray_answer: assert property (p_stray_answer) else $error("stray answer");

    // the config load lands on the first edge after release
    property p_space_load;
        $fell(i_rst) |=> space_q == {3'h0, $past(i_cfg_space_map), 1'b0};
    endproperty
    a_space_load: assert property (p_space_load) else $error("config not loaded");

    property p_addr_out;
        func_q[4][7] |=> o_pin_drive[4].level[7] == $past(i_addr_latch[7]);
    endproperty
    a_addr_out: assert property (p_addr_out) else $error("address not driven out");

    // an open-drain pin must never push a high level
    property p_open_drain;
        drive_q[0][2] && dir_q[0][2] && out_q[0][2] |=> !o_pin_drive[0].oe[2];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain driven high");

    property p_slew;
        drive_q[5] != 8'h00 |=> o_slew_fast[5] == $past(drive_q[5]) && o_slew_fast[0] == 8'h00;
    endproperty
    a_slew: assert property (p_slew) else $error("slew select wrong");

    c_pin_read: cover property (p_pin_read);
    c_pwr0_write: cover property (wr_hit(i_host, crb_pkg::OFS_PWR0));
    c_split_map: cover property (i_split_bus_mode && space_q[4:0] != 5'h1F);
    c_open_drain: cover property (o_pin_drive[0].oe[0] == 1'b0 && drive_q[0][0] && dir_q[0][0]);

endmodule : crb_config_status_bank

// ===== src/crb_pkg.sv
package crb_pkg;

    // port count and width; ports are indexed A=0 .. G=6
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;

    // per-port offsets inside the 256-byte register window
    localparam logic [7:0] OFS_DATA_IN [NUM_PORTS] =
        '{8'h00, 8'h01, 8'h10, 8'h11, 8'h30, 8'h40, 8'h41};
    localparam logic [7:0] OFS_DATA_OUT [NUM_PORTS] =
        '{8'h04, 8'h05, 8'h14, 8'h15, 8'h34, 8'h44, 8'h45};
    localparam logic [7:0] OFS_DIR [NUM_PORTS] =
        '{8'h06, 8'h07, 8'h16, 8'h17, 8'h36, 8'h46, 8'h47};
    localparam logic [7:0] OFS_DRIVE [NUM_PORTS] =
        '{8'h08, 8'h09, 8'h18, 8'h19, 8'h38, 8'h48, 8'h49};
    // function select exists on E, F, G only; other entries are masked off
    localparam logic [7:0] OFS_FUNC [NUM_PORTS] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h42, 8'h43};

    // which ports own a function select, an open-drain select or a slew select
    localparam logic [NUM_PORTS-1:0] HAS_FUNC = 7'h70;
    localparam logic [NUM_PORTS-1:0] HAS_OPEN_DRAIN = 7'h5B;
    localparam logic [NUM_PORTS-1:0] HAS_SLEW = 7'h24;

    // device-wide registers
    localparam logic [7:0] OFS_MAIN_PROT = 8'hC0;
    localparam logic [7:0] OFS_BOOT_PROT = 8'hC2;
    localparam logic [7:0] OFS_PWR0 = 8'hB0;
    localparam logic [7:0] OFS_PWR2 = 8'hB4;
    localparam logic [7:0] OFS_PAGE = 8'hE0;
    localparam logic [7:0] OFS_SPACE = 8'hE2;
    localparam logic [7:0] OFS_MEM_SIZE = 8'hF0;

    // power control 0 fields
    localparam int PWR0_APD_BIT = 1;
    localparam int PWR0_FAST_OFF_BIT = 3;
    localparam int PWR0_CLK_OFF_BIT = 4;
    localparam logic [7:0] PWR0_MASK = 8'h1A;
    // power gating fields
    localparam int PWR2_ADDR_BIT = 0;
    localparam int PWR2_CTL0_BIT = 2;
    localparam int PWR2_ALE_BIT = 5;
    localparam int PWR2_WRH_BIT = 6;
    localparam logic [7:0] PWR2_MASK = 8'h7D;
    // space mapping fields
    localparam int SPACE_CFG_LSB = 1;
    localparam int SPACE_PERIPH_BIT = 7;
    localparam logic [7:0] SPACE_MASK = 8'h9F;
    // protection and size fields
    localparam int BOOT_SECURITY_BIT = 7;
    localparam int SIZE_SRAM_LSB = 4;
    localparam logic [3:0] MAIN_SIZE_MAX = 4'h6;
    localparam logic [3:0] SRAM_SIZE_MAX = 4'h5;

    // reset values
    localparam logic [7:0] PORT_REG_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] SPACE_RST = 8'h00;

    // one host bus cycle as seen by the bank
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crb_host_req_type;

    // pad drive for one port
    typedef struct packed {
        logic [PORT_W-1:0] level;
        logic [PORT_W-1:0] oe;
    } crb_pin_drive_type;

endpackage : crb_pkg

// ===== verification/crb_host_model.sv
`timescale 1ns/10ps
// host bus master: one byte-wide cycle per call, changes only on falling edges
module crb_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output crb_pkg::crb_host_req_type o_host
);
    initial begin
        o_host = '0;
    end

    // released bus shows inverted address and data so a stale value never looks valid
    task automatic release_bus();
        o_host.sel = 1'b0;
        o_host.wr = 1'b0;
        o_host.rd = 1'b0;
        o_host.addr = ~o_host.addr;
        o_host.wdata = ~o_host.wdata;
    endtask : release_bus

    // single write cycle inside the register window, taken at one rising edge
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_core_clk);
        o_host = '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge i_core_clk);
        release_bus();
    endtask : write_byte

    // single read cycle; the answer stands in the cycle after the taking edge
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data,
                             output logic valid);
        @(negedge i_core_clk);
        o_host = '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge i_core_clk);
        release_bus();
        data = i_rdata;
        valid = i_rvalid;
    endtask : read_byte
endmodule : crb_host_model

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic i_core_clk;
    logic i_rst;
    logic i_por;
    crb_pkg::crb_host_req_type host_req;
    logic [crb_pkg::NUM_PORTS-1:0][7:0] i_pin_level;
    logic [7:0] i_addr_latch;
    logic [7:0] i_main_protect;
    logic [3:0] i_boot_protect;
    logic i_security_set;
    logic [3:0] i_cfg_space_map;
    logic i_split_bus_mode;
    logic [7:0] o_rdata;
    logic o_rvalid;
    crb_pkg::crb_pin_drive_type [crb_pkg::NUM_PORTS-1:0] o_pin_drive;
    logic [crb_pkg::NUM_PORTS-1:0][7:0] o_slew_fast;
    logic [7:0] o_page_bits;
    logic o_auto_power_down;
    logic o_logic_fast_mode_off;
    logic o_logic_clock_input_block;
    logic o_addr_block;
    logic [2:0] o_control_inputs_block;
    logic o_ale_block;
    logic o_high_byte_write_enable_block;
    logic [4:0] o_space_access_en;
    logic o_port_f_periph_en;
    int num_errors = 0;
    int checks = 0;

    // 250 MHz core clock
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // largest legal size codes, so the size byte is 56
    crb_config_status_bank #(.MAIN_SIZE_CODE(4'h6), .SRAM_SIZE_CODE(4'h5))
    crb_config_status_bank_inst (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_por(i_por), .i_host(host_req),
        .i_pin_level(i_pin_level), .i_addr_latch(i_addr_latch),
        .i_main_protect(i_main_protect), .i_boot_protect(i_boot_protect),
        .i_security_set(i_security_set), .i_cfg_space_map(i_cfg_space_map),
        .i_split_bus_mode(i_split_bus_mode), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_pin_drive(o_pin_drive), .o_slew_fast(o_slew_fast), .o_page_bits(o_page_bits),
        .o_auto_power_down(o_auto_power_down),
        .o_logic_fast_mode_off(o_logic_fast_mode_off),
        .o_logic_clock_input_block(o_logic_clock_input_block),
        .o_addr_block(o_addr_block), .o_control_inputs_block(o_control_inputs_block),
        .o_ale_block(o_ale_block),
        .o_high_byte_write_enable_block(o_high_byte_write_enable_block),
        .o_space_access_en(o_space_access_en), .o_port_f_periph_en(o_port_f_periph_en)
    );

    crb_host_model crb_host_model_inst (
        .i_core_clk(i_core_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_host(host_req)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // a read must answer with a valid pulse and the expected byte
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        crb_host_model_inst.read_byte(a, d, v);
        chk({7'h00, v, d}, {7'h01, exp});
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        crb_host_model_inst.write_byte(a, d);
    endtask : wr

    // the reset input never touches power control 0; power-up reset does
    task automatic do_reset(input logic por);
        @(negedge i_core_clk);
        i_rst = 1'b1;
        i_por = por;
        repeat (2) @(negedge i_core_clk);
        i_rst = 1'b0;
        i_por = 1'b0;
        repeat (2) @(negedge i_core_clk);
    endtask : do_reset

    task automatic report_and_stop();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // cut a hang short after far more than the few hundred cycles needed
    initial begin
        #80000;
        num_errors++;
        $display("watchdog expired at t=%0t", $time);
        report_and_stop();
    end

    initial begin
        logic [7:0] fsel, lvl, od;
        i_rst = 1'b1;
        i_por = 1'b1;
        i_pin_level = '0;
        i_addr_latch = 8'h69;
        i_main_protect = 8'hC3;
        i_boot_protect = 4'h9;
        i_security_set = 1'b1;
        i_cfg_space_map = 4'hA;
        i_split_bus_mode = 1'b0;
        do_reset(1'b1);

        // defaults after power-up
        for (int p = 0; p < crb_pkg::NUM_PORTS; p++) begin
            rd_chk(crb_pkg::OFS_DATA_OUT[p], 8'h00);
            rd_chk(crb_pkg::OFS_DIR[p], 8'h00);
            rd_chk(crb_pkg::OFS_DRIVE[p], 8'h00);
            if (crb_pkg::HAS_FUNC[p]) rd_chk(crb_pkg::OFS_FUNC[p], 8'h00);
        end
        rd_chk(crb_pkg::OFS_PAGE, 8'h00);
        rd_chk(crb_pkg::OFS_PWR0, 8'h00);
        rd_chk(crb_pkg::OFS_SPACE, 8'h14);
        chk(o_space_access_en, 16'h001F);
        $display("test defaults done");

        // port mode, direction, drive type and address-out per port
        for (int p = 0; p < crb_pkg::NUM_PORTS; p++) begin
            fsel = crb_pkg::HAS_FUNC[p] ? 8'hF0 : 8'h00;
            wr(crb_pkg::OFS_DATA_OUT[p], 8'hA5);
            wr(crb_pkg::OFS_DIR[p], 8'h0F);
            wr(crb_pkg::OFS_DRIVE[p], 8'h3C);
            if (crb_pkg::HAS_FUNC[p]) wr(crb_pkg::OFS_FUNC[p], fsel);
            @(negedge i_core_clk);
            lvl = (fsel & i_addr_latch) | (~fsel & 8'hA5);
            od = crb_pkg::HAS_OPEN_DRAIN[p] ? 8'h3C : 8'h00;
            chk(o_pin_drive[p].level, {8'h00, lvl});
            chk(o_pin_drive[p].oe, {8'h00, (8'h0F | fsel) & ~(od & lvl)});
            chk(o_slew_fast[p], crb_pkg::HAS_SLEW[p] ? 16'h003C : 16'h0000);
            rd_chk(crb_pkg::OFS_DATA_OUT[p], 8'hA5);
            rd_chk(crb_pkg::OFS_DIR[p], 8'h0F);
            rd_chk(crb_pkg::OFS_DRIVE[p], 8'h3C);
            if (crb_pkg::HAS_FUNC[p]) rd_chk(crb_pkg::OFS_FUNC[p], fsel);
        end
        $display("test port config done");

        // pin sampling, after the two synchroniser flops have settled
        @(negedge i_core_clk);
        for (int p = 0; p < crb_pkg::NUM_PORTS; p++) i_pin_level[p] = 8'hC3 ^ 8'(p);
        repeat (3) @(negedge i_core_clk);
        for (int p = 0; p < crb_pkg::NUM_PORTS; p++) begin
            rd_chk(crb_pkg::OFS_DATA_IN[p], 8'hC3 ^ 8'(p));
        end
        wr(crb_pkg::OFS_DATA_IN[0], 8'h00);
        rd_chk(crb_pkg::OFS_DATA_IN[0], 8'hC3);
        $display("test pin input done");

        // status and size bytes ignore writes; unmapped place reads zero
        wr(crb_pkg::OFS_MAIN_PROT, 8'h00);
        wr(crb_pkg::OFS_MEM_SIZE, 8'h00);
        wr(8'h20, 8'hFF);
        rd_chk(crb_pkg::OFS_MAIN_PROT, 8'hC3);
        rd_chk(crb_pkg::OFS_BOOT_PROT, 8'h89);
        rd_chk(crb_pkg::OFS_MEM_SIZE, 8'h56);
        rd_chk(8'h20, 8'h00);
        @(negedge i_core_clk);
        i_security_set = 1'b0;
        i_boot_protect = 4'h6;
        i_main_protect = 8'h18;
        rd_chk(crb_pkg::OFS_BOOT_PROT, 8'h06);
        rd_chk(crb_pkg::OFS_MAIN_PROT, 8'h18);
        $display("test status done");

        // page, power and mapping bits with their unused bits masked
        wr(crb_pkg::OFS_PAGE, 8'h5A);
        chk(o_page_bits, 16'h005A);
        wr(crb_pkg::OFS_PWR0, 8'hFF);
        rd_chk(crb_pkg::OFS_PWR0, 8'h1A);
        chk({o_auto_power_down, o_logic_fast_mode_off, o_logic_clock_input_block},
            16'h0007);
        wr(crb_pkg::OFS_PWR0, 8'h08);
        chk({o_auto_power_down, o_logic_fast_mode_off, o_logic_clock_input_block},
            16'h0002);
        wr(crb_pkg::OFS_PWR2, 8'hFF);
        rd_chk(crb_pkg::OFS_PWR2, 8'h7D);
        wr(crb_pkg::OFS_PWR2, 8'h29);
        chk({o_high_byte_write_enable_block, o_ale_block, o_control_inputs_block,
             o_addr_block}, 16'h0015);
        wr(crb_pkg::OFS_PWR2, 8'h54);
        chk({o_high_byte_write_enable_block, o_ale_block, o_control_inputs_block,
             o_addr_block}, 16'h002A);
        @(negedge i_core_clk);
        i_split_bus_mode = 1'b1;
        @(negedge i_core_clk);
        chk(o_space_access_en, 16'h0014);
        wr(crb_pkg::OFS_SPACE, 8'hFF);
        rd_chk(crb_pkg::OFS_SPACE, 8'h9F);
        chk({o_port_f_periph_en, o_space_access_en}, 16'h003F);
        wr(crb_pkg::OFS_SPACE, 8'h09);
        // the gated enables follow the mapping register one cycle later
        @(negedge i_core_clk);
        chk({o_port_f_periph_en, o_space_access_en}, 16'h0009);
        @(negedge i_core_clk);
        i_split_bus_mode = 1'b0;
        @(negedge i_core_clk);
        chk(o_space_access_en, 16'h001F);
        $display("test control regs done");

        // plain reset keeps power control 0, power-up reset clears it
        do_reset(1'b0);
        chk(o_page_bits, 16'h0000);
        rd_chk(crb_pkg::OFS_PWR0, 8'h08);
        chk(o_logic_fast_mode_off, 16'h0001);
        rd_chk(crb_pkg::OFS_SPACE, 8'h14);
        do_reset(1'b1);
        rd_chk(crb_pkg::OFS_PWR0, 8'h00);
        $display("test reset done");
        report_and_stop();
    end
endmodule : tb_top
